/* inc/emd_pkg.sv */
// package of constants for the emulation memory decoder
package emd_pkg;
	localparam int ADDR_W     = 21;
	localparam int PAGE_W     = 5;
	localparam int NUM_PAGES  = 32;
	localparam int OFFS_W     = 16;
	localparam int PHYS_W     = 21;
	typedef enum logic [1:0] {
		FIT_256K,
		FIT_1MB,
		FIT_2MB,
		FIT_RSVD
	} emd_fit_t;
	localparam logic [PAGE_W-1:0] PAGE_256K_BASE = 5'h1c;
	localparam logic [PAGE_W-1:0] PAGE_1MB_BASE  = 5'h10;
	localparam logic [PAGE_W-1:0] PAGE_CODE      = 5'h00;
	localparam logic [OFFS_W-1:0] CODE_LO        = 16'h0400;
	localparam logic [OFFS_W-1:0] CODE_HI        = 16'h0fff;
	localparam logic [NUM_PAGES-1:0] RST_POD_MAP = 32'h0000_0000;
	localparam logic [PHYS_W-1:0]    RST_PHYS    = 21'h00_0000;
endpackage

/* rtl/emd_page_sel.sv */
// page window compare: page within a base and a count of pages
`timescale 1ns/1ps
module emd_page_sel #(
	parameter logic [4:0] BASE  = 5'h00,
	parameter logic [5:0] COUNT = 6'h01
) (
	input  wire logic [4:0] page,
	output wire logic       hit,
	output wire logic [4:0] rel
);
	wire logic [5:0] diff;
	assign diff = {1'b0, page} - {1'b0, BASE};
	assign hit  = (page >= BASE) && (diff < COUNT);
	assign rel  = diff[4:0];
endmodule

/* rtl/emd_decoder.sv */
// emulation memory address decoder top
`timescale 1ns/1ps
module emd_decoder (
	input  wire logic                         clk,
	input  wire logic                         nrst,
	input  wire logic                         clkEn,
	input  wire logic [emd_pkg::ADDR_W-1:0]   coreAddr,
	input  wire logic                         coreCycle,
	input  wire emd_pkg::emd_fit_t            memFit,
	input  wire logic [emd_pkg::NUM_PAGES-1:0] podPageMap,
	output logic                              podSel_ff,
	output logic                              tgtSel_ff,
	output logic [emd_pkg::PHYS_W-1:0]        podAddr_ff,
	output logic                              cycleValid_ff
);
	import emd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// address split
	wire logic [PAGE_W-1:0] page;
	wire logic [OFFS_W-1:0] offs;
	wire logic              inCodeWin;
	wire logic              codePage;
	assign page      = coreAddr[ADDR_W-1:OFFS_W];
	assign offs      = coreAddr[OFFS_W-1:0];
	assign inCodeWin = (offs >= CODE_LO) && (offs <= CODE_HI);
	assign codePage  = (page == PAGE_CODE);

	////////////////////////////////////////////////////////////////////////
	// fitted windows
	wire logic       hit256;
	wire logic [4:0] rel256;
	wire logic       hit1m;
	wire logic [4:0] rel1m;
	emd_page_sel #(.BASE(PAGE_256K_BASE), .COUNT(6'h04)) u_sel256 (
		.page (page),
		.hit  (hit256),
		.rel  (rel256)
	);
	emd_page_sel #(.BASE(PAGE_1MB_BASE), .COUNT(6'h10)) u_sel1m (
		.page (page),
		.hit  (hit1m),
		.rel  (rel1m)
	);

	////////////////////////////////////////////////////////////////////////
	// routing
	// in the 256K and 1M fits code ram never goes to target: it is the only copy the core runs from
	wire logic aliasFit;
	wire logic codeAlias;
	wire logic pageOnPod;
	wire logic fitted;
	wire logic goPod;
	// reserved fit sends everything, code window too, to target
	assign aliasFit  = (memFit == FIT_256K) || (memFit == FIT_1MB);
	assign codeAlias = codePage && inCodeWin && aliasFit;
	assign pageOnPod = podPageMap[page];
	assign fitted    = (memFit == FIT_256K) ? hit256 :
		(memFit == FIT_1MB) ? hit1m : (memFit == FIT_2MB);
	assign goPod     = codeAlias || (fitted && pageOnPod);

	////////////////////////////////////////////////////////////////////////
	// physical pod address
	// 256K and 1M fits fold the code window onto the first fitted page;
	// a 1M image in 100400-100FFF therefore overlays code ram
	logic [PHYS_W-1:0] nxt_podAddr;
	always_comb begin
		nxt_podAddr = RST_PHYS;
		case (memFit)
			FIT_256K: nxt_podAddr = {3'h0, rel256[1:0], offs};
			FIT_1MB:  nxt_podAddr = {1'b0, rel1m[3:0], offs};
			FIT_2MB:  nxt_podAddr = coreAddr;
			default:  nxt_podAddr = RST_PHYS;
		endcase
		if (codeAlias) begin
			nxt_podAddr = {5'h00, offs};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next select values
	// idle cycles drop both selects so a stale hit never reaches the ram
	wire logic nxt_podSel;
	wire logic nxt_tgtSel;
	wire logic nxt_cycleValid;
	assign nxt_podSel     = coreCycle && goPod;
	assign nxt_tgtSel     = coreCycle && !goPod;
	assign nxt_cycleValid = coreCycle;

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			podSel_ff     <= 1'b0;
			tgtSel_ff     <= 1'b0;
			podAddr_ff    <= RST_PHYS;
			cycleValid_ff <= 1'b0;
		end else if (clkEn) begin
			podSel_ff     <= nxt_podSel;
			tgtSel_ff     <= nxt_tgtSel;
			podAddr_ff    <= nxt_podAddr;
			cycleValid_ff <= nxt_cycleValid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks: select integrity
	// each answer stands one enabled cycle, frozen cycles hold it
	a_sel_exclusive: assert property (@(posedge clk) disable iff (!nrst)
		!(podSel_ff && tgtSel_ff))
		else $error("pod and target both selected");
	a_sel_follows: assert property (@(posedge clk) disable iff (!nrst)
		$past(clkEn)
		|-> (cycleValid_ff == (podSel_ff || tgtSel_ff)))
		else $error("select does not match cycle");
	a_valid_copy: assert property (@(posedge clk) disable iff (!nrst)
		clkEn
		|=> (cycleValid_ff == $past(coreCycle)))
		else $error("cycle flag not a copy of the core cycle");
	a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && !coreCycle)
		|=> (!podSel_ff && !tgtSel_ff && !cycleValid_ff))
		else $error("select raised on an idle cycle");
	a_hold_frozen: assert property (@(posedge clk) disable iff (!nrst)
		!clkEn
		|=> ($stable(podAddr_ff) && $stable(podSel_ff)))
		else $error("state moved while disabled");
	a_hold_tgt: assert property (@(posedge clk) disable iff (!nrst)
		!clkEn
		|=> ($stable(tgtSel_ff) && $stable(cycleValid_ff)))
		else $error("target select moved while disabled");

	////////////////////////////////////////////////////////////////////////
	// checks: 256K fit
	// code window hits outrank the page map in the folded fits
	a_fit256_pages: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && !codePage && page < 5'h1c)
		|=> tgtSel_ff)
		else $error("256K fit hit outside 1C-1F");
	a_fit256_map: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && page[4:2] == 3'h7 && pageOnPod)
		|=> (podSel_ff && podAddr_ff == {3'h0, $past(page[1:0]), $past(offs)}))
		else $error("256K page not at its pod slot");
	a_fit256_top: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && memFit == FIT_256K)
		|=> (podAddr_ff[20:18] == 3'h0))
		else $error("256K pod address beyond fitted ram");
	a_code_alias: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && codePage && inCodeWin)
		|=> (podSel_ff && podAddr_ff == {5'h00, $past(offs)}))
		else $error("code ram alias wrong");
	a_code_outside: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && codePage && !inCodeWin)
		|=> tgtSel_ff)
		else $error("page 0 outside code window on pod");
	a_alias_same: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && page == 5'h1c && pageOnPod)
		|=> (podAddr_ff == {5'h00, $past(offs)}))
		else $error("page 1C not at pod base");
	a_tgt_page1c: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_256K && page == 5'h1c && !pageOnPod)
		|=> tgtSel_ff)
		else $error("page 1C to target not honoured");

	////////////////////////////////////////////////////////////////////////
	// checks: 1-MB fit
	// pages 10-1F plus the page 0 code window; page 10 overlays code ram on the pod
	a_onemb_alias: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_1MB && page == 5'h10 && pageOnPod && inCodeWin)
		|=> (podSel_ff && podAddr_ff == {5'h00, $past(offs)}))
		else $error("1MB alias wrong");
	a_onemb_pages: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_1MB && !codePage && !page[4])
		|=> tgtSel_ff)
		else $error("1MB fit hit below page 10");
	a_onemb_map: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_1MB && page[4] && pageOnPod)
		|=> (podSel_ff && podAddr_ff == {1'h0, $past(page[3:0]), $past(offs)}))
		else $error("1MB page not at its pod slot");
	a_onemb_code: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_1MB && codePage && inCodeWin)
		|=> (podSel_ff && podAddr_ff == {5'h00, $past(offs)}))
		else $error("1MB code window not on pod");
	a_onemb_nocode: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_1MB && codePage && !inCodeWin)
		|=> tgtSel_ff)
		else $error("1MB page 0 outside code window on pod");
	a_onemb_top: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && memFit == FIT_1MB)
		|=> !podAddr_ff[20])
		else $error("1MB pod address beyond fitted ram");

	////////////////////////////////////////////////////////////////////////
	// checks: 2-MB and reserved fits
	// no folding here; the page map alone decides in 2MB, reserved sends all to target
	a_twomb_flat: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_2MB && pageOnPod)
		|=> (podSel_ff && podAddr_ff == $past(coreAddr)))
		else $error("2MB address not distinct");
	a_twomb_tgt: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_2MB && !pageOnPod)
		|=> (tgtSel_ff && !podSel_ff))
		else $error("2MB unmapped page not to target");
	a_twomb_addr: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && memFit == FIT_2MB)
		|=> (podAddr_ff == $past(coreAddr)))
		else $error("2MB pod address not the core address");
	a_rsvd_target: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && coreCycle && memFit == FIT_RSVD)
		|=> (tgtSel_ff && !podSel_ff))
		else $error("reserved fit not routed to target");
	a_rsvd_addr: assert property (@(posedge clk) disable iff (!nrst)
		(clkEn && memFit == FIT_RSVD)
		|=> (podAddr_ff == RST_PHYS))
		else $error("reserved fit pod address not cleared");
endmodule

/* tb/emd_core_model.sv */
// core bus model: one address per cycle, bus shows the inverted last address when idle
`timescale 1ns/1ps
module emd_core_model (
	input  wire logic        clk,
	input  wire logic        reqCycle,
	input  wire logic [20:0] reqAddr,
	output wire logic        coreCycle,
	output wire logic [20:0] coreAddr
);
	logic [20:0] lastAddr_ff = 21'h000000;
	// idle bus shows the inverse of the last address, never a stale match
	assign coreAddr = reqCycle ? reqAddr : ~lastAddr_ff;
	assign coreCycle = reqCycle;
	always_ff @(posedge clk) if (reqCycle) lastAddr_ff <= reqAddr;
endmodule

/* tb/emulation_memory_decoder_tb.sv */
// self-checking bench for the emulation memory decoder
`timescale 1ns/1ps
module emulation_memory_decoder_tb;
	import emd_pkg::*;
	logic        clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, reqCycle = 1'b0;
	logic [20:0] reqAddr = 21'h000000, coreAddr, podAddr;
	logic        coreCycle, podSel, tgtSel, cycleValid;
	emd_fit_t    memFit = FIT_256K;
	logic [31:0] podPageMap = 32'h0000_0000;
	int          error_cnt = 0, checks_done = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	emd_core_model core_u (.clk(clk), .reqCycle(reqCycle), .reqAddr(reqAddr),
		.coreCycle(coreCycle), .coreAddr(coreAddr));
	emd_decoder dut_u (.clk(clk), .nrst(nrst), .clkEn(clkEn), .coreAddr(coreAddr),
		.coreCycle(coreCycle), .memFit(memFit), .podPageMap(podPageMap),
		.podSel_ff(podSel), .tgtSel_ff(tgtSel), .podAddr_ff(podAddr),
		.cycleValid_ff(cycleValid));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// answer lands one edge later, so judge at the next falling edge
	task automatic acc(input logic [20:0] a, input logic pod, input logic [20:0] pa);
		@(negedge clk);
		reqAddr = a;
		reqCycle = 1'b1;
		@(negedge clk);
		reqCycle = 1'b0;
		chk({20'h0, podSel}, {20'h0, pod});
		chk({20'h0, tgtSel}, {20'h0, ~pod});
		chk({20'h0, cycleValid}, 21'h000001);
		if (pod) chk(podAddr, pa);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_fit256;
		podPageMap = 32'hf000_0000;
		acc(21'h1c0500, 1'b1, 21'h000500);
		acc(21'h000fff, 1'b1, 21'h000fff);
		acc(21'h1f1234, 1'b1, 21'h031234);
		acc(21'h1b0500, 1'b0, 21'h000000);
		acc(21'h001000, 1'b0, 21'h000000);
		podPageMap = 32'he000_0000;
		acc(21'h1c0500, 1'b0, 21'h000000);
		acc(21'h000400, 1'b1, 21'h000400);
	endtask
	// bench keeps no separate contents in the aliased range
	task automatic t_fit1mb;
		memFit = FIT_1MB;
		podPageMap = 32'hffff_0000;
		acc(21'h100500, 1'b1, 21'h000500);
		acc(21'h1f0010, 1'b1, 21'h0f0010);
		acc(21'h0f0000, 1'b0, 21'h000000);
		acc(21'h000fff, 1'b1, 21'h000fff);
		acc(21'h0003ff, 1'b0, 21'h000000);
	endtask
	task automatic t_fit2mb;
		memFit = FIT_2MB;
		podPageMap = 32'h1000_0000;
		acc(21'h1c0500, 1'b1, 21'h1c0500);
		acc(21'h000500, 1'b0, 21'h000000);
		podPageMap = 32'hffff_ffff;
		acc(21'h000500, 1'b1, 21'h000500);
		acc(21'h1fffff, 1'b1, 21'h1fffff);
	endtask
	task automatic t_rsvd;
		memFit = FIT_RSVD;
		podPageMap = 32'hffff_ffff;
		acc(21'h000500, 1'b0, 21'h000000);
		chk(podAddr, RST_PHYS);
		acc(21'h1c0500, 1'b0, 21'h000000);
		chk(podAddr, RST_PHYS);
	endtask
	// second request is held off by a low enable, first answer must stand
	task automatic t_freeze;
		memFit = FIT_256K;
		podPageMap = 32'hf000_0000;
		@(negedge clk);
		reqAddr = 21'h1f1234;
		reqCycle = 1'b1;
		@(negedge clk);
		clkEn = 1'b0;
		reqAddr = 21'h1b0500;
		@(negedge clk);
		chk({20'h0, podSel}, 21'h000001);
		chk({20'h0, tgtSel}, 21'h000000);
		chk(podAddr, 21'h031234);
		clkEn = 1'b1;
		reqCycle = 1'b0;
	endtask
	task automatic t_reset;
		memFit = FIT_256K;
		podPageMap = 32'hf000_0000;
		acc(21'h1f1234, 1'b1, 21'h031234);
		nrst = 1'b0;
		#1;
		chk({20'h0, podSel}, 21'h000000);
		chk({20'h0, tgtSel}, 21'h000000);
		chk({20'h0, cycleValid}, 21'h000000);
		chk(podAddr, RST_PHYS);
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		acc(21'h000500, 1'b1, 21'h000500);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		t_fit256();
		t_fit1mb();
		t_fit2mb();
		t_rsvd();
		t_freeze();
		t_reset();
		tally_and_finish();
	end
endmodule
